/* rtl/uhs_pkg.sv */
// Shared constants for the host descriptor scheduler.
// Assumes one 16-bit register port and a 64-word descriptor memory.
package uhs_pkg;
    // Register offsets on the 10-bit register port.
    localparam logic [9:0] REG_CTRL  = 10'h000;  // Go flag and list kind.
    localparam logic [9:0] REG_STAT  = 10'h004;  // Buffer activity.
    localparam logic [9:0] REG_SIZE  = 10'h008;  // Entry payload size.
    localparam logic [9:0] REG_BYP   = 10'h00c;  // Bypass bitmap.
    localparam logic [9:0] REG_FINAL = 10'h010;  // Final entry mask.
    localparam logic [9:0] REG_DONE  = 10'h014;  // Completion bitmap.
    localparam logic [9:0] REG_THR   = 10'h018;  // Completions per request.
    localparam logic [9:0] REG_FRAME = 10'h01c;  // Frame counter.
    localparam logic [9:0] MEM_BASE  = 10'h100;  // Descriptor memory window.
    // Reset values.
    localparam logic [15:0] RST_SIZE  = 16'h0008;
    localparam logic [15:0] RST_BYP   = 16'hffff;
    localparam logic [15:0] RST_FINAL = 16'h0001;
    // Header field positions, word 0.
    localparam int W0_CC = 12;
    localparam int W0_ACT = 11;
    localparam int W0_TOG = 10;
    // Word 1: speed bit and endpoint at the top.
    localparam int W1_SPEED = 10;
    localparam int W1_EP = 12;
    // Word 2: direction/token and pairing bits.
    localparam int W2_DIR = 10;
    localparam int W2_HALF = 14;
    localparam int W2_PAIR = 15;
    // Outcome codes.
    localparam logic [3:0] CC_PEND = 4'hf;
    localparam logic [3:0] CC_OK = 4'h0;
    // List kinds.
    localparam logic [1:0] KIND_APER = 2'h0;
    localparam logic [1:0] KIND_INTR = 2'h1;
    localparam logic [1:0] KIND_ISO = 2'h2;
    // Direction/token codes and packet identifiers.
    localparam logic [1:0] DT_SETUP = 2'h0;
    localparam logic [1:0] DT_OUT = 2'h1;
    localparam logic [1:0] DT_IN = 2'h2;
    localparam logic [3:0] PID_SETUP = 4'hd;
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_DATA0 = 4'h3;
    localparam logic [3:0] PID_DATA1 = 4'hb;
    // Scheduler states.
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SCAN  = 5'b00010,
        ST_ISSUE = 5'b00100,
        ST_WAIT  = 5'b01000,
        ST_NEXT  = 5'b10000
    } uhs_state_t;
endpackage : uhs_pkg

/* rtl/uhs_token_decode.sv */
// Token and packet length decode for one transfer descriptor.
// Assumes header fields come straight from descriptor memory.
`timescale 1ns/10ps
module uhs_token_decode (
    // Descriptor fields.
    input  wire logic [1:0] direction_token_code,
    input  wire logic       toggle,
    input  wire logic [9:0] remaining,
    input  wire logic [9:0] pktLimit,
    // Decoded results.
    output logic [3:0]      tokenPid,
    output logic [3:0]      dataPid,
    output logic            reserved,
    output logic [9:0]      pktLen
);
    import uhs_pkg::*;

    // Token field decode; the fourth code is reserved and never sent.
    always_comb begin
        reserved = 1'b0;
        case (direction_token_code)
            DT_SETUP: tokenPid = PID_SETUP;
            DT_OUT:   tokenPid = PID_OUT;
            DT_IN:    tokenPid = PID_IN;
            default: begin
                tokenPid = PID_OUT;
                reserved = 1'b1;
            end
        endcase
    end

    // Toggle picks DATA0 or DATA1.
    assign dataPid = toggle ? PID_DATA1 : PID_DATA0;

    // A count larger than the packet limit is split over packets.
    assign pktLen = (remaining > pktLimit) ? pktLimit : remaining;
endmodule : uhs_token_decode

/* rtl/uhs_frame_gate.sv */
// Decides whether a periodic descriptor may run in the current frame.
// Assumes the frame number is from the same clock domain.
`timescale 1ns/10ps
module uhs_frame_gate (
    // Descriptor and frame.
    input  wire logic [1:0]  listKind,
    input  wire logic [7:0]  frameByte,
    input  wire logic [15:0] frameNum,
    // Result.
    output logic             eligible
);
    import uhs_pkg::*;

    logic [6:0] rateMask;  // Low frame bits that must match.
    logic [7:0] startFull; // Start frame widened for comparison.

    // Interval is 2 to the power of the rate code, 1 to 128 frames.
    always_comb begin
        rateMask = 7'(({7'h00, 1'b1} << frameByte[7:5]) - 8'h01);
        startFull = {3'h0, frameByte[4:0]};
        case (listKind)
            KIND_INTR: eligible = ((frameNum[6:0] ^ startFull[6:0]) & rateMask) == 7'h00;
            KIND_ISO:  eligible = frameNum[7:0] == frameByte;
            default:   eligible = 1'b1;
        endcase
    end
endmodule : uhs_frame_gate

/* rtl/uhs_scheduler.sv */
// Descriptor scheduler: walks the descriptor buffer and issues transactions.
// Assumes a packet engine on the same clock that moves payload via the engine port.
`timescale 1ns/10ps
module uhs_scheduler (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port.
    input  wire logic [9:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdData,
    // Frame start from the frame timer.
    input  wire logic        sofPulse,
    // Transaction request to the packet engine.
    output logic             txnValid,
    input  wire logic        txnReady,
    output logic [3:0]       txnTokenPid,
    output logic [3:0]       txnDataPid,
    output logic [6:0]       txnFuncAddr,
    output logic [3:0]       txnEndpoint,
    output logic             txnLowSpeed,
    output logic [9:0]       txnLen,
    output logic [5:0]       txnBufAddr,
    // Transaction result.
    input  wire logic        resValid,
    input  wire logic        resAck,
    input  wire logic [3:0]  resCode,
    input  wire logic [9:0]  resBytes,
    // Payload access for the engine.
    input  wire logic [5:0]  engRdAddr,
    output logic [15:0]      engRdData,
    input  wire logic        engWr,
    input  wire logic [5:0]  engWrAddr,
    input  wire logic [15:0] engWrData,
    // Request to the host processor.
    output logic             irqReq
);
    import uhs_pkg::*;

    logic [15:0] mem_q [64], mem_d [64]; // Descriptor buffer, 16-bit words.
    uhs_state_t  state_q, state_d;       // Scheduler state.
    logic [3:0]  idx_q, idx_d;           // Entry being scanned.
    logic        go_q, go_d;             // Buffer go flag.
    logic [1:0]  kind_q, kind_d;         // List kind.
    logic [15:0] size_q, size_d;         // Payload bytes per entry.
    logic [15:0] byp_q, byp_d;           // Bypass bitmap.
    logic [15:0] fin_q, fin_d;           // Final entry mask.
    logic [15:0] done_q, done_d;         // Completion bitmap.
    logic [15:0] thr_q, thr_d;           // Completions per request.
    logic [15:0] cnt_q, cnt_d;           // Completions counted.
    logic [15:0] frame_q, frame_d;       // Frame counter.
    logic [15:0] served_q, served_d;     // Periodic entries run this frame.
    logic [15:0] pingOk_q, pingOk_d;     // First half descriptor finished.
    logic        irq_q, irq_d;           // Request level.
    logic        pong_q, pong_d;         // Second half on the line.
    logic [15:0] rd_q, rd_d;             // Read data.
    logic [15:0] eng_q, eng_d;           // Engine read data.
    logic        tv_q, tv_d;             // Request valid.
    logic [3:0]  tok_q, tok_d, dp_q, dp_d, ep_q, ep_d;
    logic [6:0]  fa_q, fa_d;
    logic        ls_q, ls_d;
    logic [9:0]  len_q, len_d;
    logic [5:0]  ba_q, ba_d;

    // Header word base of an entry: eight header bytes, then payload.
    function automatic logic [5:0] entryBase(input logic [3:0] i, input logic [15:0] sz);
        logic [9:0] stride;
        stride = 10'(sz[10:1]) + 10'h004;
        return 6'(stride * 10'(i));
    endfunction : entryBase

    logic [5:0]  base;
    logic [15:0] w0, w1, w2, w3;
    logic [9:0]  actual, remaining, pktLen, newActual;
    logic [3:0]  tokenPid, dataPid;
    logic        reservedTok, gateOk, paired, secondHalf, eligible, finish;

    assign base = entryBase(idx_q, size_q);
    assign w0 = mem_q[base];
    assign w1 = mem_q[6'(base + 6'h01)];
    assign w2 = mem_q[6'(base + 6'h02)];
    assign w3 = mem_q[6'(base + 6'h03)];
    assign actual = w0[9:0];
    assign remaining = w2[9:0] - actual;
    assign paired = w2[W2_PAIR];
    assign secondHalf = paired & w2[W2_HALF];

    uhs_token_decode uDecode (
        .direction_token_code  (w2[W2_DIR +: 2]),
        .toggle    (w0[W0_TOG]),
        .remaining (remaining),
        .pktLimit  (w1[9:0]),
        .tokenPid  (tokenPid),
        .dataPid   (dataPid),
        .reserved  (reservedTok),
        .pktLen    (pktLen)
    );

    uhs_frame_gate uGate (
        .listKind  (kind_q),
        .frameByte (w3[15:8]),
        .frameNum  (frame_q),
        .eligible  (gateOk)
    );

    // An entry runs if active, not bypassed, in frame and past its first half.
    assign eligible = w0[W0_ACT] && !byp_q[idx_q] && gateOk && !reservedTok
                      && !(kind_q != KIND_APER && served_q[idx_q])
                      && !(secondHalf && !pingOk_q[4'(idx_q - 4'h1)]);

    assign newActual = 10'(actual + resBytes);
    // Errors, or a full or short data stage, finish the descriptor.
    assign finish = (resCode != CC_OK) || (resAck && (newActual >= w2[9:0] || resBytes < len_q));

    // Next-state logic for the scheduler, registers and memory.
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        go_d = go_q;
        kind_d = kind_q;
        size_d = size_q;
        byp_d = byp_q;
        fin_d = fin_q;
        done_d = done_q;
        thr_d = thr_q;
        cnt_d = cnt_q;
        frame_d = sofPulse ? 16'(frame_q + 16'h0001) : frame_q;
        served_d = sofPulse ? 16'h0000 : served_q;
        pingOk_d = pingOk_q;
        irq_d = irq_q;
        pong_d = pong_q;
        mem_d = mem_q;
        tv_d = tv_q;
        {tok_d, dp_d, ep_d, fa_d, ls_d, len_d, ba_d} = {tok_q, dp_q, ep_q, fa_q, ls_q, len_q, ba_q};
        eng_d = mem_q[engRdAddr];
        rd_d = 16'h0000;
        // Register reads answer one cycle later; unmapped reads give zero.
        if (regRd) begin
            case (regAddr)
                REG_CTRL:  rd_d = {13'h0000, kind_q, go_q};
                REG_STAT:  rd_d = {10'h000, idx_q, pong_q, state_q != ST_IDLE};
                REG_SIZE:  rd_d = size_q;
                REG_BYP:   rd_d = byp_q;
                REG_FINAL: rd_d = fin_q;
                REG_DONE:  rd_d = done_q;
                REG_THR:   rd_d = thr_q;
                REG_FRAME: rd_d = frame_q;
                default: begin
                    if (regAddr >= MEM_BASE && regAddr < 10'(MEM_BASE + 10'h100)) begin
                        rd_d = mem_q[regAddr[7:2]];
                    end
                end
            endcase
        end
        // Register writes; writes to read-only or unmapped words are dropped.
        if (regWr) begin
            case (regAddr)
                REG_CTRL: begin
                    go_d = regWrData[0];
                    kind_d = regWrData[2:1];
                end
                REG_SIZE:  size_d = regWrData;
                REG_BYP:   byp_d = regWrData;
                REG_FINAL: fin_d = regWrData;
                REG_DONE: begin
                    done_d = done_q & ~regWrData;
                    irq_d = 1'b0;
                end
                REG_THR: begin
                    thr_d = regWrData;
                    cnt_d = 16'h0000;
                end
                REG_FRAME: frame_d = regWrData;
                default: begin
                    if (regAddr >= MEM_BASE && regAddr < 10'(MEM_BASE + 10'h100)) begin
                        mem_d[regAddr[7:2]] = regWrData;
                    end
                end
            endcase
        end
        // IN payload from the engine lands straight in the buffer.
        if (engWr) begin
            mem_d[engWrAddr] = engWrData;
        end
        case (state_q)
            ST_IDLE: begin
                idx_d = 4'h0;
                if (go_q) begin
                    state_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (!go_q) begin
                    state_d = ST_IDLE;
                end else if (eligible) begin
                    tv_d = 1'b1;
                    tok_d = tokenPid;
                    dp_d = dataPid;
                    ep_d = w1[W1_EP +: 4];
                    fa_d = w3[6:0];
                    ls_d = w1[W1_SPEED];
                    len_d = pktLen;
                    ba_d = 6'(base + 6'h04 + 6'(actual[9:1]));
                    pong_d = secondHalf;
                    state_d = ST_ISSUE;
                end else begin
                    state_d = ST_NEXT;
                end
            end
            ST_ISSUE: begin
                if (txnReady) begin
                    tv_d = 1'b0;
                    if (kind_q != KIND_APER) begin
                        served_d[idx_q] = 1'b1;
                    end
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (resValid) begin
                    // Successful data stage advances count and toggle.
                    if (resAck && resCode == CC_OK) begin
                        mem_d[base][9:0] = newActual;
                        mem_d[base][W0_TOG] = ~w0[W0_TOG];
                    end
                    if (finish) begin
                        mem_d[base][W0_ACT] = 1'b0;
                        mem_d[base][W0_CC +: 4] = resCode;
                        done_d[idx_q] = 1'b1;
                        cnt_d = 16'(cnt_d + 16'h0001);
                        // Completion wins over a clear in the same cycle.
                        if (thr_q != 16'h0000 && cnt_d >= thr_q) begin
                            irq_d = 1'b1;
                            cnt_d = 16'h0000;
                        end
                        if (paired) begin
                            pingOk_d[idx_q] = !secondHalf;
                            if (secondHalf) begin
                                pingOk_d[4'(idx_q - 4'h1)] = 1'b0;
                            end
                        end
                    end
                    pong_d = 1'b0;
                    state_d = ST_NEXT;
                end
            end
            ST_NEXT: begin
                // Wrap after the final entry so pairs keep alternating in a frame.
                idx_d = fin_q[idx_q] ? 4'h0 : 4'(idx_q + 4'h1);
                state_d = ST_SCAN;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // State registers with synchronous reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            idx_q <= 4'h0;
            go_q <= 1'b0;
            kind_q <= KIND_APER;
            size_q <= RST_SIZE;
            byp_q <= RST_BYP;
            fin_q <= RST_FINAL;
            done_q <= 16'h0000;
            thr_q <= 16'h0000;
            cnt_q <= 16'h0000;
            frame_q <= 16'h0000;
            served_q <= 16'h0000;
            pingOk_q <= 16'h0000;
            irq_q <= 1'b0;
            pong_q <= 1'b0;
            rd_q <= 16'h0000;
            eng_q <= 16'h0000;
            tv_q <= 1'b0;
            {tok_q, dp_q, ep_q, fa_q, ls_q, len_q, ba_q} <= '0;
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= 16'h0000;
            end
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            go_q <= go_d;
            kind_q <= kind_d;
            size_q <= size_d;
            byp_q <= byp_d;
            fin_q <= fin_d;
            done_q <= done_d;
            thr_q <= thr_d;
            cnt_q <= cnt_d;
            frame_q <= frame_d;
            served_q <= served_d;
            pingOk_q <= pingOk_d;
            irq_q <= irq_d;
            pong_q <= pong_d;
            rd_q <= rd_d;
            eng_q <= eng_d;
            tv_q <= tv_d;
            {tok_q, dp_q, ep_q, fa_q, ls_q, len_q, ba_q} <= {tok_d, dp_d, ep_d, fa_d, ls_d, len_d, ba_d};
            mem_q <= mem_d;
        end
    end

    assign regRdData = rd_q;
    assign engRdData = eng_q;
    assign irqReq = irq_q;
    assign txnValid = tv_q;
    assign txnTokenPid = tok_q;
    assign txnDataPid = dp_q;
    assign txnEndpoint = ep_q;
    assign txnFuncAddr = fa_q;
    assign txnLowSpeed = ls_q;
    assign txnLen = len_q;
    assign txnBufAddr = ba_q;

    // Checks on the scheduler's own behaviour.
    sequence issueSeq;
        state_q == ST_SCAN && go_q && eligible;
    endsequence
    go_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(txnValid) |-> $past(go_q)) else $error("request without go flag");
    bypass_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(txnValid) |-> !$past(byp_q[idx_q])) else $error("bypassed entry issued");
    speed_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        issueSeq |=> txnLowSpeed == $past(w1[W1_SPEED])) else $error("speed bit lost");
    token_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issueSeq and (w2[W2_DIR +: 2] == DT_IN)) |=> txnTokenPid == PID_IN) else $error("IN token wrong");
    addr_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        issueSeq |=> txnFuncAddr == $past(w3[6:0])) else $error("function address wrong");
    len_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        txnValid |-> txnLen <= w1[9:0]) else $error("packet too long");
    pong_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issueSeq and secondHalf) |-> pingOk_q[4'(idx_q - 4'h1)]) else $error("second half early");
    active_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ST_WAIT && resValid && finish |=> !mem_q[$past(base)][W0_ACT] && done_q[$past(idx_q)])
        else $error("active not cleared");
    iso_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issueSeq and (kind_q == KIND_ISO)) |-> frame_q[7:0] == w3[15:8]) else $error("iso frame mismatch");
    read_lat_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        regRd && regAddr == REG_DONE |=> regRdData == $past(done_q)) else $error("bitmap read wrong");
endmodule : uhs_scheduler

/* tb/uhs_engine_model.sv */
// Behavioural packet engine standing where the USB peripherals are.
// Assumes one outstanding transaction and a result that always succeeds.
`timescale 1ns/10ps
module uhs_engine_model (
    // Clock, reset and pacing.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] delay,
    // Transaction request.
    input  wire logic       txnValid,
    input  wire logic [9:0] txnLen,
    input  wire logic [5:0] txnBufAddr,
    output logic            txnReady,
    // Result and buffer access.
    output logic            resValid,
    output logic            resAck,
    output logic [3:0]      resCode,
    output logic [9:0]      resBytes,
    output logic [5:0]      engRdAddr,
    output logic            engWr,
    output logic [5:0]      engWrAddr,
    output logic [15:0]     engWrData
);
    logic       busyQ; // A request was taken and its result is owed.
    logic [3:0] cntQ;  // Cycles waited in the current phase.
    // Every packet is acknowledged in full; faults are not modelled.
    assign resAck = 1'b1;
    assign resCode = 4'h0;
    assign engWr = 1'b0;
    assign engWrAddr = 6'h00;
    assign engWrData = 16'h0000;
    // Ready after a chosen delay, result four cycles later.
    always_ff @(posedge ref_clk) begin
        txnReady <= 1'b0;
        resValid <= 1'b0;
        if (!rst_n) begin
            busyQ <= 1'b0;
            cntQ <= 4'h0;
            resBytes <= 10'h000;
            engRdAddr <= 6'h00;
        end else if (busyQ) begin
            // The byte count is only meaningful beside the result pulse.
            resBytes <= (cntQ == 4'h3) ? resBytes : ~resBytes;
            cntQ <= (cntQ == 4'h3) ? 4'h0 : cntQ + 4'h1;
            resValid <= (cntQ == 4'h3);
            busyQ <= (cntQ != 4'h3);
        end else if (txnValid && !txnReady) begin
            if (cntQ == delay) begin
                txnReady <= 1'b1;
                busyQ <= 1'b1;
                resBytes <= ~txnLen;
                engRdAddr <= txnBufAddr;
                cntQ <= 4'h0;
            end else begin
                cntQ <= cntQ + 4'h1;
            end
        end
    end
endmodule : uhs_engine_model

/* tb/usb_host_descriptor_scheduler_tb.sv */
// Self-checking bench for the descriptor scheduler with an engine model.
// Assumes the register map and descriptor layout of the shared package.
`timescale 1ns/10ps
module usb_host_descriptor_scheduler_tb;
    import uhs_pkg::*;
    logic ref_clk, rst_n, regWr, regRd, sofPulse, txnValid, txnReady, txnLowSpeed, resValid, resAck, engWr, irqReq;
    logic [9:0] regAddr, txnLen, resBytes;
    logic [15:0] regWrData, regRdData, engRdData, engWrData;
    logic [3:0] txnTokenPid, txnDataPid, txnEndpoint, resCode, dly, ep;
    logic [6:0] txnFuncAddr, fa;
    logic [5:0] txnBufAddr, engRdAddr, engWrAddr;
    logic [35:0] expQ[$]; // Expected transactions, oldest first.
    logic [15:0] expW0[16]; // Expected header word 0 of each entry after its run.
    int fails, compares, cycles;
    uhs_scheduler uhs_scheduler_inst (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sofPulse(sofPulse), .txnValid(txnValid),
        .txnReady(txnReady), .txnTokenPid(txnTokenPid), .txnDataPid(txnDataPid), .txnFuncAddr(txnFuncAddr),
        .txnEndpoint(txnEndpoint), .txnLowSpeed(txnLowSpeed), .txnLen(txnLen), .txnBufAddr(txnBufAddr),
        .resValid(resValid), .resAck(resAck), .resCode(resCode), .resBytes(resBytes), .engRdAddr(engRdAddr),
        .engRdData(engRdData), .engWr(engWr), .engWrAddr(engWrAddr), .engWrData(engWrData), .irqReq(irqReq));
    uhs_engine_model uhs_engine_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .delay(dly), .txnValid(txnValid),
        .txnLen(txnLen), .txnBufAddr(txnBufAddr), .txnReady(txnReady), .resValid(resValid), .resAck(resAck),
        .resCode(resCode), .resBytes(resBytes), .engRdAddr(engRdAddr), .engWr(engWr), .engWrAddr(engWrAddr),
        .engWrData(engWrData));
    // Free-running 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    // Read data is looked at in the one cycle where it stands.
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk("regRdData", {20'h0, e}, {20'h0, regRdData});
    endtask : rd
    function automatic logic [3:0] tp(input logic [1:0] d);
        return (d == DT_SETUP) ? PID_SETUP : (d == DT_OUT) ? PID_OUT : PID_IN;
    endfunction : tp
    // Loads one entry and notes its packets; pr is {paired, half}, b7 is header byte 7.
    task automatic load(input int idx, input logic [1:0] dt, input logic low, input logic [9:0] total,
        input logic [1:0] pr, input logic [7:0] b7);
        logic [9:0] rem, act, len;
        logic tog;
        int b;
        rem = total;
        act = 10'h000;
        tog = 1'b0;
        b = idx * 8;
        // A second half serves the same function and endpoint as its first half.
        if (pr != 2'b11) begin
            fa = 7'($urandom);
            ep = 4'($urandom);
        end
        wr(MEM_BASE + 10'(4 * b), 16'hf800);
        wr(MEM_BASE + 10'(4 * b + 4), {ep, 1'b0, low, 10'h008});
        wr(MEM_BASE + 10'(4 * b + 8), {pr, 2'b00, dt, total});
        wr(MEM_BASE + 10'(4 * b + 12), {b7, 1'b0, fa});
        while (rem != 10'h000) begin
            len = (rem > 10'h008) ? 10'h008 : rem;
            expQ.push_back({tp(dt), tog ? PID_DATA1 : PID_DATA0, fa, ep, low, len, 6'(b + 4 + act / 2)});
            act = act + len;
            rem = rem - len;
            tog = ~tog;
        end
        expW0[idx] = {5'h00, tog, act};
    endtask : load
    // Starts the list of the given kind and checks request, bitmap and headers of the entries in mask.
    task automatic run(input logic [15:0] mask, input logic [15:0] thr, input logic [1:0] kind);
        int i;
        wr(REG_THR, thr);
        dly <= 4'($urandom % 6);
        // Nothing may go out before the go flag; the monitor flags strays only once no note is pending.
        repeat (20) @(posedge ref_clk);
        wr(REG_CTRL, {13'h0000, kind, 1'b1});
        for (i = 0; i < 500 && irqReq !== 1'b1; i++) @(posedge ref_clk);
        chk("irqReq", 36'h1, {35'h0, irqReq});
        rd(REG_DONE, mask);
        for (i = 0; i < 16; i++) begin
            if (mask[i]) rd(MEM_BASE + 10'(32 * i), expW0[i]);
        end
        chk("pending", 36'h0, 36'(expQ.size()));
        wr(REG_DONE, mask);
        wr(REG_CTRL, 16'h0000);
        #1 chk("irqClear", 36'h0, {35'h0, irqReq});
    endtask : run
    // Each accepted request is compared with the oldest note.
    always @(posedge ref_clk) begin
        if (rst_n && txnValid === 1'b1 && txnReady === 1'b1) begin
            if (expQ.size() == 0) begin
                chk("stray txn", 36'h0, 36'hfffffffff);
            end else begin
                chk("txn", expQ.pop_front(), {txnTokenPid, txnDataPid, txnFuncAddr, txnEndpoint,
                    txnLowSpeed, txnLen, txnBufAddr});
            end
        end
    end
    // Hang guard: the whole run needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h1655));
        {rst_n, regWr, regRd, sofPulse, regAddr, regWrData, dly} = '0;
        fails = 0;
        compares = 0;
        cycles = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_SIZE, RST_SIZE);
        rd(REG_BYP, RST_BYP);
        rd(REG_FINAL, RST_FINAL);
        rd(10'h020, 16'h0000);
        wr(REG_STAT, 16'hffff);
        rd(REG_STAT, 16'h0000);
        wr(REG_BYP, 16'hfffe);
        for (int t = 0; t < 3; t++) begin
            load(0, 2'(t), t[0], 10'(8 + 12 * t), 2'b00, 8'h00);
            run(16'h0001, 16'h0001, KIND_APER);
        end
        // Entry 0 is active but bypassed; only entry 1 may run.
        wr(REG_BYP, 16'hfffd);
        wr(REG_FINAL, 16'h0002);
        wr(MEM_BASE, 16'hf800);
        load(1, DT_OUT, 1'b0, 10'h005, 2'b00, 8'h00);
        run(16'h0002, 16'h0001, KIND_APER);
        rd(MEM_BASE, 16'hf800);
        // The first half needs two packets; the second half may only follow once it is finished.
        wr(REG_BYP, 16'hfffc);
        load(0, DT_OUT, 1'b0, 10'h010, 2'b10, 8'h00);
        load(1, DT_OUT, 1'b0, 10'h008, 2'b11, 8'h00);
        run(16'h0003, 16'h0002, KIND_APER);
        // Periodic lists: isochronous on an exact frame, then interrupt on its rate.
        wr(REG_FRAME, 16'h0042);
        load(0, DT_IN, 1'b0, 10'h008, 2'b00, 8'h42);
        run(16'h0001, 16'h0001, KIND_ISO);
        @(posedge ref_clk);
        sofPulse <= 1'b1;
        @(posedge ref_clk);
        sofPulse <= 1'b0;
        rd(REG_FRAME, 16'h0043);
        load(0, DT_IN, 1'b1, 10'h008, 2'b00, 8'h23);
        run(16'h0001, 16'h0001, KIND_INTR);
        report_and_stop();
    end
endmodule : usb_host_descriptor_scheduler_tb
